/* rtl/pdlc_addr_gen.sv */
// dma address generator: counts words in memory mode, holds the fifo id otherwise
`timescale 1ns/1ps
`default_nettype none
module pdlc_addr_gen
    import pdlc_pkg::*;
(
    input  wire logic clk,
    input  wire logic sys_rst,
    pdlc_addr_if.gen  ag
);
    logic [ADDR_W-1:0] addr_r;
    logic [ADDR_W-1:0] addr_nxt;

    always_comb begin
        addr_nxt = addr_r;
        if (ag.load) begin
            addr_nxt = ag.base;
        end else if (ag.step && !ag.fifo_mode) begin
            // one address unit is one 128-bit word
            addr_nxt = addr_r + ADDR_STEP;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            addr_r <= ADDR_RST;
        end else begin
            addr_r <= addr_nxt;
        end
    end

    assign ag.addr = addr_r;

    addr_incr_a: assert property (@(posedge clk) disable iff (sys_rst)
        (!ag.load && ag.step && !ag.fifo_mode) |=> addr_r == $past(addr_r) + ADDR_STEP)
        else $error("memory mode address did not advance by one word");
    fifo_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        (!ag.load && ag.fifo_mode) |=> $stable(addr_r))
        else $error("fifo id changed during a fifo-link transfer");
endmodule
`default_nettype wire

/* rtl/pdlc_channel.sv */
// local-side dma channel: drives read and write requests toward user logic
// ----------------------------------------------------------------------------
// Notes on behaviour
// - one dma channel, memory or fifo-link mode
// - mode select high for fifo, low memory
// - fifo mode puts fifo id on address
// - memory mode address steps one word each
// - everything on the output local interface clock
// ----------------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module pdlc_channel
    import pdlc_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              sys_rst,
    // command side
    input  wire logic              cmd_start,
    input  wire logic              cmd_write,
    input  wire logic              cmd_fifo_mode,
    input  wire logic [ADDR_W-1:0] cmd_addr,
    input  wire logic [LEN_W-1:0]  cmd_len,
    output logic                   cmd_ready,
    output logic                   cmd_done,
    // host-side write words
    input  wire logic [DATA_W-1:0] host_wr_word,
    input  wire logic              host_wr_valid,
    output logic                   host_wr_ready,
    // host-side read words
    output logic [DATA_W-1:0]      host_rd_word,
    output logic                   dma_read_valid_alias,
    // local interface
    output logic                   local_interface_clock,
    output logic                   dma_mode_select,
    output logic [ADDR_W-1:0]      dma_read_address,
    output logic                   dma_read_request,
    input  wire logic [DATA_W-1:0] dma_read_word,
    input  wire logic              dma_read_word_valid,
    output logic [ADDR_W-1:0]      dma_write_address,
    output logic [DATA_W-1:0]      dma_write_word,
    output logic                   dma_write_strobe
);
    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    pdlc_state_t       state_r,    state_nxt;
    logic              mode_r,     mode_nxt;
    logic [LEN_W-1:0]  req_left_r, req_left_nxt;
    logic [LEN_W-1:0]  rcv_left_r, rcv_left_nxt;
    logic              rd_req_r,   rd_req_nxt;
    logic [ADDR_W-1:0] rd_addr_r,  rd_addr_nxt;
    logic [DATA_W-1:0] rd_word_r,  rd_word_nxt;
    logic              rd_val_r,   rd_val_nxt;
    logic              wr_stb_r,   wr_stb_nxt;
    logic [ADDR_W-1:0] wr_addr_r,  wr_addr_nxt;
    logic [DATA_W-1:0] wr_word_r,  wr_word_nxt;
    logic              done_r,     done_nxt;
    logic              start_ok;
    logic              wr_take;

    pdlc_addr_if ag ();

    pdlc_addr_gen u_addr_gen (
        .clk     (clk),
        .sys_rst (sys_rst),
        .ag      (ag)
    );

    // the user logic runs on the very clock that clocks this channel
    assign local_interface_clock = clk;

    assign cmd_ready     = (state_r == PDLC_IDLE);
    assign start_ok      = cmd_start && cmd_ready;
    assign host_wr_ready = (state_r == PDLC_WRITE) && (req_left_r != LEN_RST);
    assign wr_take       = host_wr_ready && host_wr_valid;

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    always_comb begin
        state_nxt    = state_r;
        mode_nxt     = mode_r;
        req_left_nxt = req_left_r;
        rcv_left_nxt = rcv_left_r;
        rd_req_nxt   = 1'b0;
        rd_addr_nxt  = rd_addr_r;
        rd_word_nxt  = rd_word_r;
        rd_val_nxt   = 1'b0;
        wr_stb_nxt   = 1'b0;
        wr_addr_nxt  = wr_addr_r;
        wr_word_nxt  = wr_word_r;
        done_nxt     = 1'b0;
        ag.load      = 1'b0;
        ag.base      = cmd_addr;
        ag.step      = 1'b0;
        ag.fifo_mode = mode_r;
        // late words are still taken while draining; words outside a read are ignored
        if (dma_read_word_valid && (state_r == PDLC_READ || state_r == PDLC_DRAIN)) begin
            rd_word_nxt  = dma_read_word;
            rd_val_nxt   = 1'b1;
            rcv_left_nxt = rcv_left_r - LEN_W'(1);
        end
        case (state_r)
            PDLC_IDLE: begin
                if (start_ok) begin
                    // one channel, one mode per transfer
                    mode_nxt     = cmd_fifo_mode;
                    ag.load      = 1'b1;
                    req_left_nxt = cmd_len;
                    rcv_left_nxt = cmd_len;
                    state_nxt    = cmd_write ? PDLC_WRITE : PDLC_READ;
                end
            end
            PDLC_READ: begin
                if (req_left_r != LEN_RST) begin
                    // requests go out back to back with no handshake; returned words are counted, so the latency may vary
                    rd_req_nxt   = 1'b1;
                    rd_addr_nxt  = ag.addr;
                    ag.step      = 1'b1;
                    req_left_nxt = req_left_r - LEN_W'(1);
                end else begin
                    state_nxt = PDLC_DRAIN;
                end
            end
            PDLC_DRAIN: begin
                if (rcv_left_r == LEN_RST) begin
                    done_nxt  = 1'b1;
                    state_nxt = PDLC_IDLE;
                end
            end
            PDLC_WRITE: begin
                if (wr_take) begin
                    wr_stb_nxt   = 1'b1;
                    wr_word_nxt  = host_wr_word;
                    wr_addr_nxt  = ag.addr;
                    ag.step      = 1'b1;
                    req_left_nxt = req_left_r - LEN_W'(1);
                end else if (req_left_r == LEN_RST) begin
                    done_nxt  = 1'b1;
                    state_nxt = PDLC_IDLE;
                end
            end
            default: begin
                state_nxt = PDLC_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r    <= PDLC_IDLE;
            mode_r     <= 1'b0;
            req_left_r <= LEN_RST;
            rcv_left_r <= LEN_RST;
            rd_req_r   <= 1'b0;
            rd_addr_r  <= ADDR_RST;
            rd_word_r  <= '0;
            rd_val_r   <= 1'b0;
            wr_stb_r   <= 1'b0;
            wr_addr_r  <= ADDR_RST;
            wr_word_r  <= '0;
            done_r     <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            mode_r     <= mode_nxt;
            req_left_r <= req_left_nxt;
            rcv_left_r <= rcv_left_nxt;
            rd_req_r   <= rd_req_nxt;
            rd_addr_r  <= rd_addr_nxt;
            rd_word_r  <= rd_word_nxt;
            rd_val_r   <= rd_val_nxt;
            wr_stb_r   <= wr_stb_nxt;
            wr_addr_r  <= wr_addr_nxt;
            wr_word_r  <= wr_word_nxt;
            done_r     <= done_nxt;
        end
    end

    assign dma_mode_select      = mode_r;
    assign dma_read_request     = rd_req_r;
    assign dma_read_address     = rd_addr_r;
    assign host_rd_word         = rd_word_r;
    assign dma_read_valid_alias = rd_val_r;
    assign dma_write_strobe     = wr_stb_r;
    assign dma_write_address    = wr_addr_r;
    assign dma_write_word       = wr_word_r;
    assign cmd_done             = done_r;

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    sequence mem_req_pair_s;
        (dma_read_request && !dma_mode_select) ##1 dma_read_request;
    endsequence

    sequence fifo_req_pair_s;
        (dma_read_request && dma_mode_select) ##1 dma_read_request;
    endsequence

    sequence wr_accept_s;
        wr_take && !mode_r;
    endsequence

    one_dir_a: assert property (@(posedge clk) disable iff (sys_rst)
        !(dma_read_request && dma_write_strobe))
        else $error("read and write active together");
    mode_follow_a: assert property (@(posedge clk) disable iff (sys_rst)
        start_ok |=> dma_mode_select == $past(cmd_fifo_mode) && !cmd_ready)
        else $error("mode select does not follow the command mode");
    fifo_addr_a: assert property (@(posedge clk) disable iff (sys_rst)
        fifo_req_pair_s |-> dma_read_address == $past(dma_read_address))
        else $error("fifo id moved between read requests");
    mem_step_a: assert property (@(posedge clk) disable iff (sys_rst)
        mem_req_pair_s |-> dma_read_address == $past(dma_read_address) + ADDR_STEP)
        else $error("read address did not step by one word");
    wr_pair_a: assert property (@(posedge clk) disable iff (sys_rst)
        wr_take |=> dma_write_strobe && dma_write_word == $past(host_wr_word))
        else $error("write strobe not paired with its word");
    wr_step_a: assert property (@(posedge clk) disable iff (sys_rst)
        wr_accept_s ##1 wr_accept_s |=> dma_write_address == $past(dma_write_address) + ADDR_STEP)
        else $error("write address did not step by one word");
    rd_capture_a: assert property (@(posedge clk) disable iff (sys_rst)
        (dma_read_word_valid && state_r == PDLC_READ) |=> dma_read_valid_alias
            && host_rd_word == $past(dma_read_word))
        else $error("returned read word not forwarded");
    zero_len_a: assert property (@(posedge clk) disable iff (sys_rst)
        (start_ok && cmd_write && cmd_len == LEN_RST) |=> ##1 cmd_done && !dma_write_strobe)
        else $error("empty write did not finish at once");
endmodule
`default_nettype wire

/* shared/pdlc_addr_if.sv */
// address generator control bundle
`timescale 1ns/1ps
`default_nettype none
interface pdlc_addr_if;
    import pdlc_pkg::*;
    logic              load;
    logic [ADDR_W-1:0] base;
    logic              step;
    logic              fifo_mode;
    logic [ADDR_W-1:0] addr;
    modport ctl (output load, output base, output step, output fifo_mode, input addr);
    modport gen (input load, input base, input step, input fifo_mode, output addr);
endinterface
`default_nettype wire

/* shared/pdlc_pkg.sv */
// shared constants and types of the local dma channel
package pdlc_pkg;
    localparam int          ADDR_W        = 32;
    localparam int          DATA_W        = 128;
    localparam int          LEN_W         = 32;
    localparam int          READ_LATENCY  = 2;
    localparam logic [31:0] ADDR_RST      = 32'h0000_0000;
    localparam logic [31:0] LEN_RST       = 32'h0000_0000;
    localparam logic [31:0] ADDR_STEP     = 32'h0000_0001;

    typedef enum logic [1:0] {
        PDLC_IDLE,
        PDLC_READ,
        PDLC_DRAIN,
        PDLC_WRITE
    } pdlc_state_t;
endpackage

/* tb/pdlc_user_mem.sv */
// user logic model: answers dma reads after two or three cycles
`timescale 1ns/1ps
`default_nettype none
module pdlc_user_mem
    import pdlc_pkg::*;
(
    input  wire logic              local_interface_clock,
    input  wire logic              slow,
    input  wire logic              dma_read_request,
    input  wire logic [ADDR_W-1:0] dma_read_address,
    output logic [DATA_W-1:0]      dma_read_word,
    output logic                   dma_read_word_valid
);
    logic [2:0]        v_r = '0;
    logic              t_r = 1'b0;
    logic [ADDR_W-1:0] a_r [3];
    logic [ADDR_W-1:0] a_o;
    // -------------------------------------------------------------------
    // read pipeline
    // -------------------------------------------------------------------
    // everything is taken on the clock the device hands out
    always @(posedge local_interface_clock) begin
        v_r <= {v_r[1:0], dma_read_request};
        a_r[0] <= dma_read_address;
        a_r[1] <= a_r[0];
        a_r[2] <= a_r[1];
        t_r <= ~t_r;
    end
    // valid two cycles after the request, one more when slow
    assign dma_read_word_valid = slow ? v_r[READ_LATENCY] : v_r[READ_LATENCY-1];
    assign a_o = slow ? a_r[READ_LATENCY] : a_r[READ_LATENCY-1];
    // outside valid the bus churns so a stale word never looks good
    assign dma_read_word = dma_read_word_valid ? {4{~a_o}} : {(DATA_W/2){t_r, ~t_r}};
endmodule
`default_nettype wire

/* tb/test_pcie_dma_local_channel.sv */
// self-checking bench of the local dma channel
`timescale 1ns/1ps
`default_nettype none
module test_pcie_dma_local_channel
    import pdlc_pkg::*;
;
    logic              clk, sys_rst, cmd_start, cmd_write, cmd_fifo_mode, cmd_ready, cmd_done;
    logic              host_wr_valid, host_wr_ready, dma_read_valid_alias, local_interface_clock;
    logic              dma_mode_select, dma_read_request, dma_read_word_valid, dma_write_strobe, slow;
    logic [ADDR_W-1:0] cmd_addr, cmd_len, dma_read_address, dma_write_address, base;
    logic [DATA_W-1:0] host_wr_word, host_rd_word, dma_read_word, dma_write_word;
    logic              fm;
    int                fails, compares, wn, rn, qn, sent, cyc;

    pdlc_channel i_dut (.clk, .sys_rst, .cmd_start, .cmd_write, .cmd_fifo_mode, .cmd_addr, .cmd_len,
        .cmd_ready, .cmd_done, .host_wr_word, .host_wr_valid, .host_wr_ready, .host_rd_word,
        .dma_read_valid_alias, .local_interface_clock, .dma_mode_select, .dma_read_address,
        .dma_read_request, .dma_read_word, .dma_read_word_valid, .dma_write_address,
        .dma_write_word, .dma_write_strobe);
    pdlc_user_mem i_mem (.local_interface_clock, .slow, .dma_read_request, .dma_read_address,
        .dma_read_word, .dma_read_word_valid);

    function automatic logic [DATA_W-1:0] hw(int i);
        return {4{i[31:0] ^ 32'h5a5a_5a5a}};
    endfunction
    function automatic logic [ADDR_W-1:0] ea(int i);
        return fm ? base : base + i;
    endfunction

    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("counts compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // -------------------------------------------------------------------
    // port monitor
    // -------------------------------------------------------------------
    // host words change off the sampling edge, one step after each word taken
    always @(negedge clk) begin
        host_wr_word = hw(sent);
    end

    always @(posedge clk) begin
        cyc++;
        if (host_wr_valid && host_wr_ready) sent++;
        if (dma_write_strobe) begin
            check(dma_write_address, ea(wn));
            check(dma_write_word, hw(wn));
            check(dma_mode_select, fm);
            wn++;
        end
        if (dma_read_request) begin
            check(dma_read_address, ea(qn));
            qn++;
        end
        if (dma_read_valid_alias) begin
            check(host_rd_word, {4{~ea(rn)}});
            rn++;
        end
        // a hang ends the run here; nothing may follow the verdict
        if (cyc > 3000) begin
            fails++;
            close_out();
        end
    end

    // one transfer; for lengths above one, a start held one extra cycle while busy must be ignored
    task automatic run(input logic w, input logic f, input logic s, input logic [31:0] a, input int n);
        int k;
        @(negedge clk);
        wn = 0;
        rn = 0;
        qn = 0;
        sent = 0;
        base = a;
        fm = f;
        slow = s;
        cmd_write = w;
        cmd_fifo_mode = f;
        cmd_addr = a;
        cmd_len = n;
        cmd_start = 1'b1;
        host_wr_valid = w;
        k = n > 1 ? 2 : 1;
        repeat (k) @(negedge clk);
        cmd_start = 1'b0;
        while (cmd_done !== 1'b1 && k < 200) begin
            @(negedge clk);
            k++;
        end
        host_wr_valid = 1'b0;
        check(k < 200, 1'b1);
        check(w ? wn : rn, n);
        check(qn, w ? 0 : n);
        check(dma_mode_select, f);
        check(local_interface_clock, clk);
        check(host_wr_ready, 1'b0);
        if (n == 0) check(k, w ? 2 : 3);
        $display("test done write=%0d fifo=%0d len=%0d", w, f, n);
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // reset held four cycles, released off the clock edge
    task automatic test_reset();
        sys_rst = 1'b1;
        repeat (4) @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
        check(cmd_ready, 1'b1);
        check(dma_write_strobe | dma_read_request, 1'b0);
        $display("test done reset");
    endtask

    // memory-mode write that wraps over the top of the address space
    task automatic test_mem_write();
        run(1'b1, 1'b0, 1'b0, 32'hffff_fffe, 3);
    endtask

    // memory-mode read, back-to-back requests
    task automatic test_mem_read();
        run(1'b0, 1'b0, 1'b0, 32'h0000_0010, 4);
    endtask

    // fifo-link write, the id must not move
    task automatic test_fifo_write();
        run(1'b1, 1'b1, 1'b0, 32'h0000_0007, 2);
    endtask

    // fifo-link read against a slow partner
    task automatic test_fifo_read();
        run(1'b0, 1'b1, 1'b1, 32'h0000_0003, 3);
    endtask

    // empty write finishes without a strobe
    task automatic test_empty_write();
        run(1'b1, 1'b0, 1'b0, 32'h0000_0000, 0);
    endtask

    // empty read finishes without a request
    task automatic test_empty_read();
        run(1'b0, 1'b0, 1'b0, 32'h0000_0005, 0);
    endtask

    initial begin
        {cmd_start, cmd_write, cmd_fifo_mode, host_wr_valid, slow, fm} = '0;
        {cmd_addr, cmd_len, base} = '0;
        test_reset();
        test_mem_write();
        test_mem_read();
        test_fifo_write();
        test_fifo_read();
        test_empty_write();
        test_empty_read();
        close_out();
    end
endmodule
`default_nettype wire
